// File: rtl/psm_if.sv
// Purpose: Processor bus between requester and sparse translator
// Assumes: One request outstanding at a time, single clock
// Notes: Request fields hold steady from req rise until ack
`timescale 1ns/10ps
`default_nettype none
interface psm_if;
  import psm_pkg::*;
  logic req;
  logic write;
  logic [CPU_AW-1:3] addr;
  logic [3:0] lw_mask;
  logic second;
  logic [QW_W-1:0] wdata;
  logic ack;
  logic [QW_W-1:0] rdata;

  modport host (
    output req, write, addr, lw_mask, second, wdata,
    input ack, rdata
  );
  modport dev (
    input req, write, addr, lw_mask, second, wdata,
    output ack, rdata
  );
endinterface
`default_nettype wire

// File: rtl/psm_pkg.sv
// Purpose: Shared constants and types for the sparse memory translator
// Assumes: Processor addresses are 40 bits, PCI addresses 32 bits
// Notes: Both ends and the size decoder import this package
package psm_pkg;
  localparam int CPU_AW = 40;
  localparam int PCI_AW = 32;
  localparam int EXT_W = 32;
  localparam int LW_W = 32;
  localparam int QW_W = 64;
  // Sparse memory window: 80.0000.0000 up to 85.7FFF.FFFF
  localparam logic [4:0] SPARSE_TOP = 5'h10;
  localparam logic [2:0] REG1_LAST = 3'h3;
  localparam logic [2:0] REG2_SEL = 3'h4;
  localparam logic [2:0] REG3_SEL = 3'h5;
  // Size field values
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_TRI = 2'h2;
  localparam logic [1:0] SZ_LONG = 2'h3;
  localparam logic [1:0] OFF_0 = 2'h0;
  localparam logic [1:0] OFF_1 = 2'h1;
  localparam logic [1:0] OFF_2 = 2'h2;
  localparam logic [1:0] OFF_3 = 2'h3;
  // Active-low byte enables
  localparam logic [3:0] BE_B0 = 4'hE;
  localparam logic [3:0] BE_B1 = 4'hD;
  localparam logic [3:0] BE_B2 = 4'hB;
  localparam logic [3:0] BE_B3 = 4'h7;
  localparam logic [3:0] BE_W0 = 4'hC;
  localparam logic [3:0] BE_W1 = 4'h9;
  localparam logic [3:0] BE_W2 = 4'h3;
  localparam logic [3:0] BE_T0 = 4'h8;
  localparam logic [3:0] BE_T1 = 4'h1;
  localparam logic [3:0] BE_ALL = 4'h0;
  localparam logic [3:0] BE_NONE = 4'hF;
  // Longword valid mask patterns
  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_L0 = 4'h1;
  localparam logic [3:0] MASK_L1 = 4'h2;
  localparam logic [3:0] MASK_H0 = 4'h4;
  localparam logic [3:0] MASK_H1 = 4'h8;
  localparam logic [3:0] MASK_QUAD = 4'hC;
  // PCI commands
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_IDLE = 4'h0;

  typedef enum logic [1:0] {DEV_IDLE, DEV_BUSY, DEV_RESP} psm_dev_st_e;
  typedef enum logic [1:0] {HST_IDLE, HST_WAIT, HST_DONE} psm_hst_st_e;
endpackage

// File: rtl/psm_requester.sv
// Purpose: Processor-side master issuing sparse memory references
// Assumes: User places sub-longword data in its byte lanes itself
// Notes: Waits for each answer, so writes can never merge
`timescale 1ns/10ps
`default_nettype none
module psm_requester
  import psm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // User command
  input wire logic u_req,
  input wire logic u_write,
  input wire logic [CPU_AW-1:0] u_addr,
  input wire logic [QW_W-1:0] u_wdata,
  // User answer
  output logic u_busy,
  output logic u_done,
  output logic [QW_W-1:0] u_rdata,
  // Processor bus
  psm_if.host cpu
);
  typedef struct packed {
    psm_hst_st_e st;
    logic req;
    logic write;
    logic [CPU_AW-1:3] addr;
    logic [3:0] mask;
    logic second;
    logic [QW_W-1:0] wdata;
    logic done;
    logic [QW_W-1:0] rdata;
  } psm_hst_s;

  psm_hst_s st_r;
  psm_hst_s st_nxt;
  logic [1:0] size;
  logic quad;

  assign size = u_addr[4:3];
  assign quad = (size == SZ_LONG) && (u_addr[6:5] == OFF_3);

  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    case (st_r.st)
      HST_IDLE: begin
        if (u_req) begin
          st_nxt.req = 1'b1;
          st_nxt.write = u_write;
          st_nxt.addr = u_addr[CPU_AW-1:3];
          st_nxt.wdata = u_wdata;
          st_nxt.mask = MASK_NONE;
          st_nxt.second = 1'b0;
          if (u_write) begin
            // Size travels in the mask, not the address
            st_nxt.addr[4:3] = SZ_BYTE;
            if (quad) begin
              st_nxt.mask = MASK_QUAD;
              st_nxt.second = 1'b1;
            end else begin
              st_nxt.mask = size[0] ? MASK_H0 : MASK_L0;
              st_nxt.second = size[1];
            end
          end
          st_nxt.st = HST_WAIT;
        end
      end
      HST_WAIT: begin
        if (cpu.ack) begin
          // Next reference only after completion acts as a barrier
          st_nxt.req = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.rdata = cpu.rdata;
          st_nxt.st = HST_DONE;
        end
      end
      HST_DONE: begin
        st_nxt.st = HST_IDLE;
      end
      default: begin
        st_nxt.st = HST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{st: HST_IDLE, req: 1'b0, write: 1'b0,
                addr: {(CPU_AW-3){1'b0}}, mask: MASK_NONE, second: 1'b0,
                wdata: {QW_W{1'b0}}, done: 1'b0, rdata: {QW_W{1'b0}}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign u_busy = st_r.req;
  assign u_done = st_r.done;
  assign u_rdata = st_r.rdata;
  assign cpu.req = st_r.req;
  assign cpu.write = st_r.write;
  assign cpu.addr = st_r.addr;
  assign cpu.lw_mask = st_r.mask;
  assign cpu.second = st_r.second;
  assign cpu.wdata = st_r.wdata;
endmodule
`default_nettype wire

// File: rtl/psm_translator.sv
// Purpose: Turns processor sparse memory accesses into PCI memory cycles
// Assumes: PCI master side holds nothing but one cycle at a time
// Notes: The window extension is a plain input, no register here
//
// How it works
// - Claim 80.0000.0000 to 85.7FFF.FFFF as sparse.
// - Address bits 7:3 encode size, enables, ad low.
// - Extension bits relocate each region upward.
// - Byte size: offsets give single-lane enables.
// - Word and tribyte enables per offset.
// - Longword enables all; quadword ad 000.
// - ad2 copies bit 7 except for quadwords; ad1:0 always zero.
// - Enables are active low per lane.
// - Processor bits 30:8 drive ad 25:3.
// - ad 31:26 chosen per region from extension and address bits 33:31.
// - Undefined combinations complete without error.
// - Requester places sub-longword data in lanes.
// - Data lanes keep position; a non-quad upper longword moves to bits 31:0.
// - Requester uses quadword ops only for quadwords.
// - No prefetch; read only requested bytes.
// - Read mask lines must stay zero.
// - Write size bits come from mask and cycle.
// - Requester sends only listed write masks.
// - Requester separates mergeable writes with barriers.
// - Requester orders sparse against dense with barriers.
`timescale 1ns/10ps
`default_nettype none
module psm_translator
  import psm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Processor side
  psm_if.dev cpu,
  // Window extension bits set by software
  input wire logic [EXT_W-1:0] mem_window_extension,
  // PCI master request
  output logic pci_req,
  output logic [3:0] pci_cmd,
  output logic [PCI_AW-1:0] pci_addr,
  output logic [3:0] pci_be_n,
  output logic pci_quad,
  output logic [QW_W-1:0] pci_wdata,
  // PCI completion
  input wire logic pci_done,
  input wire logic [QW_W-1:0] pci_rdata
);
  typedef struct packed {
    psm_dev_st_e st;
    logic req;
    logic [3:0] cmd;
    logic [PCI_AW-1:0] addr;
    logic [3:0] be_n;
    logic quad;
    logic [QW_W-1:0] wdata;
    logic ack;
    logic [QW_W-1:0] rdata;
  } psm_dev_s;

  psm_dev_s st_r;
  psm_dev_s st_nxt;

  logic [1:0] wr_size;
  logic wr_hi;
  logic [1:0] size;
  logic [1:0] offs;
  logic is_quad;
  logic hit;
  logic [3:0] be_n;
  logic [5:0] ad_high;
  logic [PCI_AW-1:0] ad;
  logic [QW_W-1:0] lanes;

  psm_wsize u_wsize (
    .lw_mask(cpu.lw_mask),
    .second(cpu.second),
    .size(wr_size),
    .lane_hi(wr_hi)
  );

  // Size from address on reads, from the mask on writes
  assign size = cpu.write ? wr_size : cpu.addr[4:3];
  assign offs = cpu.addr[6:5];
  assign is_quad = (size == SZ_LONG) && (offs == OFF_3);

  // Window decode; upper half of 85 belongs to sparse I/O
  always_comb begin
    hit = 1'b0;
    if (cpu.addr[39:35] == SPARSE_TOP) begin
      if (cpu.addr[34:32] <= REG2_SEL) begin
        hit = 1'b1;
      end else if (cpu.addr[34:32] == REG3_SEL) begin
        hit = ~cpu.addr[31];
      end
    end
  end

  // Enables, active low, one bit per byte lane
  always_comb begin
    be_n = BE_NONE;
    case ({size, offs})
      {SZ_BYTE, OFF_0}: be_n = BE_B0;
      {SZ_BYTE, OFF_1}: be_n = BE_B1;
      {SZ_BYTE, OFF_2}: be_n = BE_B2;
      {SZ_BYTE, OFF_3}: be_n = BE_B3;
      {SZ_WORD, OFF_0}: be_n = BE_W0;
      {SZ_WORD, OFF_1}: be_n = BE_W1;
      {SZ_WORD, OFF_2}: be_n = BE_W2;
      {SZ_TRI, OFF_0}: be_n = BE_T0;
      {SZ_TRI, OFF_1}: be_n = BE_T1;
      {SZ_LONG, OFF_0}: be_n = BE_ALL;
      {SZ_LONG, OFF_3}: be_n = BE_ALL;
      // Gaps still run on the bus with no lane enabled, no error
      default: be_n = BE_NONE;
    endcase
  end

  // Upper PCI address bits per region
  always_comb begin
    ad_high = {mem_window_extension[7:2]};
    if (cpu.addr[34:32] <= REG1_LAST) begin
      ad_high = {mem_window_extension[31:29], cpu.addr[33:31]};
    end else if (cpu.addr[34:32] == REG2_SEL) begin
      ad_high = {mem_window_extension[15:11], cpu.addr[31]};
    end
  end

  // Quadword address from bits 30:8; bit 7 dropped for quadwords
  assign ad = {ad_high, cpu.addr[30:8],
               is_quad ? 1'b0 : cpu.addr[7], 2'b00};

  // Lanes keep their position; only the longword half is chosen
  always_comb begin
    lanes = cpu.wdata;
    if (!is_quad && wr_hi) begin
      lanes = {{LW_W{1'b0}}, cpu.wdata[QW_W-1:LW_W]};
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    case (st_r.st)
      DEV_IDLE: begin
        if (cpu.req && hit) begin
          st_nxt.req = 1'b1;
          st_nxt.cmd = cpu.write ? CMD_MEM_WR : CMD_MEM_RD;
          st_nxt.addr = ad;
          st_nxt.be_n = be_n;
          st_nxt.quad = is_quad;
          st_nxt.wdata = cpu.write ? lanes : {QW_W{1'b0}};
          st_nxt.st = DEV_BUSY;
        end else if (cpu.req) begin
          // Not ours: answer with zeros so the requester never hangs
          st_nxt.ack = 1'b1;
          st_nxt.rdata = {QW_W{1'b0}};
          st_nxt.st = DEV_RESP;
        end
      end
      DEV_BUSY: begin
        if (pci_done) begin
          st_nxt.req = 1'b0;
          st_nxt.cmd = CMD_IDLE;
          st_nxt.ack = 1'b1;
          // Only the fetched lanes come back, nothing read ahead
          st_nxt.rdata = (st_r.cmd == CMD_MEM_RD) ? pci_rdata
                                                  : {QW_W{1'b0}};
          st_nxt.st = DEV_RESP;
        end
      end
      DEV_RESP: begin
        // One idle cycle lets the requester drop req before re-decode
        st_nxt.st = DEV_IDLE;
      end
      default: begin
        st_nxt.st = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{st: DEV_IDLE, req: 1'b0, cmd: CMD_IDLE,
                addr: {PCI_AW{1'b0}}, be_n: BE_NONE, quad: 1'b0,
                wdata: {QW_W{1'b0}}, ack: 1'b0, rdata: {QW_W{1'b0}}};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs
  assign pci_req = st_r.req;
  assign pci_cmd = st_r.cmd;
  assign pci_addr = st_r.addr;
  assign pci_be_n = st_r.be_n;
  assign pci_quad = st_r.quad;
  assign pci_wdata = st_r.wdata;
  assign cpu.ack = st_r.ack;
  assign cpu.rdata = st_r.rdata;
endmodule
`default_nettype wire

// File: rtl/psm_wsize.sv
// Purpose: Recover size bits and longword half of a sparse write
// Assumes: Mask is one of the listed write patterns
// Notes: Purely combinational, used by the translator end
`timescale 1ns/10ps
`default_nettype none
module psm_wsize
  import psm_pkg::*;
(
  // Write mask and data cycle
  input wire logic [3:0] lw_mask,
  input wire logic second,
  // Recovered fields
  output logic [1:0] size,
  output logic lane_hi
);
  // Odd mask bits mark the upper longword of the quadword
  assign lane_hi = lw_mask[1] | lw_mask[3];

  always_comb begin
    size = SZ_BYTE;
    case (lw_mask)
      MASK_L0, MASK_L1: size = second ? SZ_TRI : SZ_BYTE;
      MASK_H0, MASK_H1: size = second ? SZ_LONG : SZ_WORD;
      MASK_QUAD: size = SZ_LONG;
      // Other patterns are unpredictable; still mapped to something
      default: size = SZ_BYTE;
    endcase
  end
endmodule
`default_nettype wire

// File: tb/pci_sparse_mem_translator_tb.sv
// Purpose: Self-checking bench for both ends of the sparse translator
// Assumes: Bench plays the PCI target with a random answer delay
// Notes: Expectations come from the bench package helpers
`timescale 1ns/10ps
`default_nettype none
module pci_sparse_mem_translator_tb
  import psm_pkg::*, psm_tb_pkg::*;
;
  logic clk;
  logic rst_b;
  logic u_req;
  logic u_write;
  logic [CPU_AW-1:0] u_addr;
  logic [QW_W-1:0] u_wdata;
  logic u_busy;
  logic u_done;
  logic [QW_W-1:0] u_rdata;
  logic [EXT_W-1:0] mem_window_extension;
  logic pci_req;
  logic [3:0] pci_cmd;
  logic [PCI_AW-1:0] pci_addr;
  logic [3:0] pci_be_n;
  logic pci_quad;
  logic [QW_W-1:0] pci_wdata;
  logic pci_done;
  logic [QW_W-1:0] pci_rdata;
  int n_errors;
  int tests_run;
  int i;
  logic [39:0] a;
  logic [39:0] edges [9] = '{40'h80_0000_0000, 40'h83_FFFF_FFF8,
    40'h84_0000_0000, 40'h84_FFFF_FFF8, 40'h85_0000_0000,
    40'h85_7FFF_FFF8, 40'h85_8000_0000, 40'h7F_FFFF_FFF8, 40'h86_0000_0000};
  psm_if u_if();
  psm_requester psm_requester_inst(.clk, .rst_b, .u_req, .u_write, .u_addr,
    .u_wdata, .u_busy, .u_done, .u_rdata, .cpu(u_if.host));
  psm_translator psm_translator_inst(.clk, .rst_b, .cpu(u_if.dev),
    .mem_window_extension, .pci_req, .pci_cmd, .pci_addr, .pci_be_n,
    .pci_quad, .pci_wdata, .pci_done, .pci_rdata);
  psm_chk psm_chk_inst(.clk, .rst_b, .req(u_if.req), .write(u_if.write),
    .addr(u_if.addr), .lw_mask(u_if.lw_mask), .second(u_if.second),
    .wdata(u_if.wdata), .ack(u_if.ack), .rdata(u_if.rdata),
    .mem_window_extension, .pci_req, .pci_cmd, .pci_addr, .pci_be_n,
    .pci_quad, .pci_wdata, .pci_done, .pci_rdata);
  always #50 clk = ~clk;
  task automatic chk(input string nm, input logic [63:0] got,
    input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s exp=%h got=%h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic logic [39:0] rnd_win();
    logic [39:0] r;
    r = {8'h80, $urandom};
    r[34:32] = 3'($urandom_range(5, 0));
    if (r[34:32] == 3'h5) r[31] = 1'b0;
    r[2:0] = 3'h0;
    return r;
  endfunction
  // Entered and left just after a rising edge, with the requester idle
  task automatic xfer(input logic w, input logic [39:0] ad, input int lat);
    logic [63:0] d;
    logic [63:0] rd;
    logic [63:0] gw;
    logic [31:0] ga;
    logic [3:0] gb;
    logic [3:0] gc;
    logic q;
    int c;
    int k;
    d = {$urandom, $urandom};
    rd = {$urandom, $urandom};
    c = 0;
    q = ad[6:3] == 4'hF;
    mem_window_extension = $urandom;
    u_req = 1'b1;
    u_write = w;
    u_addr = ad;
    u_wdata = d;
    @(posedge clk) #1;
    u_req = 1'b0;
    chk("u_busy", 64'(u_busy), 64'h1);
    for (k = 0; k < 40 && u_done !== 1'b1; k++) begin
      pci_done = 1'b0;
      pci_rdata = ~rd;
      if (pci_req === 1'b1) begin
        if (c == 0) {ga, gb, gc, gw} = {pci_addr, pci_be_n, pci_cmd, pci_wdata};
        if (c == lat) {pci_done, pci_rdata} = {1'b1, rd};
        c++;
      end
      @(posedge clk) #1;
    end
    if (k >= 40) begin
      chk("u_done", 64'h0, 64'h1);
      test_done();
    end
    chk("u_busy_end", 64'(u_busy), 64'h0);
    chk("pci_cycle", 64'(c != 0), 64'(in_win(ad)));
    if (in_win(ad)) begin
      chk("pci_addr", 64'(ga), 64'(ad_of(ad, mem_window_extension, q)));
      chk("pci_be_n", 64'(gb), 64'(be_of(ad[4:3], ad[6:5])));
      chk("pci_cmd", 64'(gc), 64'(w ? CMD_MEM_WR : CMD_MEM_RD));
      if (w) chk("pci_wdata", q ? gw : 64'(gw[31:0]), q ? d : 64'(d[31:0]));
    end
    if (!w) chk("u_rdata", u_rdata, in_win(ad) ? rd : 64'h0);
    @(posedge clk) #1;
  endtask
  initial begin
    {clk, rst_b, u_req, u_write, pci_done} = 5'h0;
    {u_addr, u_wdata, pci_rdata, mem_window_extension} = '0;
    {n_errors, tests_run} = '0;
    void'($urandom(42));
    repeat (6) @(posedge clk);
    #1 rst_b = 1'b1;
    // Every size and offset code, read then write
    for (i = 0; i < 32; i++) begin
      a = rnd_win();
      a[6:3] = i[3:0];
      xfer(i[4], a, i % 4);
    end
    for (i = 0; i < 18; i++) xfer(i[0], edges[i / 2], 1);
    for (i = 0; i < 60; i++) begin
      xfer(1'($urandom_range(1, 0)), rnd_win(), $urandom_range(3, 0));
    end
    test_done();
  end
endmodule
`default_nettype wire

// File: tb/psm_chk.sv
// Purpose: Protocol and mapping checks on the sparse translator
// Assumes: One request outstanding, single clock
// Notes: Watches the processor bus and the PCI master side
`timescale 1ns/10ps
`default_nettype none
module psm_chk
  import psm_pkg::*, psm_tb_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Processor bus
  input wire logic req,
  input wire logic write,
  input wire logic [CPU_AW-1:3] addr,
  input wire logic [3:0] lw_mask,
  input wire logic second,
  input wire logic [QW_W-1:0] wdata,
  input wire logic ack,
  input wire logic [QW_W-1:0] rdata,
  // PCI master side
  input wire logic [EXT_W-1:0] mem_window_extension,
  input wire logic pci_req,
  input wire logic [3:0] pci_cmd,
  input wire logic [PCI_AW-1:0] pci_addr,
  input wire logic [3:0] pci_be_n,
  input wire logic pci_quad,
  input wire logic [QW_W-1:0] pci_wdata,
  input wire logic pci_done,
  input wire logic [QW_W-1:0] pci_rdata
);
  logic [1:0] sz;
  logic quad;
  logic hit;
  // Writes lose bits 4:3 on the bus, so size comes back from the mask
  assign sz = write ? wsz(lw_mask, second) : addr[4:3];
  assign quad = sz == SZ_LONG && addr[6:5] == OFF_3;
  assign hit = in_win({addr, 3'h0});
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take;
    $rose(req);
  endsequence
  sequence s_pci_end;
    pci_req && pci_done;
  endsequence
  a_hit_starts: assert property (s_take ##0 hit |=> pci_req)
    else $error("window hit started no PCI cycle");
  a_miss_quiet: assert property (s_take ##0 !hit |->
    !pci_req ##1 (ack && !pci_req) ##1 !pci_req)
    else $error("miss mishandled");
  a_cmd_dir: assert property (pci_req |->
    pci_cmd == (write ? CMD_MEM_WR : CMD_MEM_RD)) else $error("bad cmd");
  a_addr_map: assert property (pci_req |->
    pci_addr == ad_of({addr, 3'h0}, mem_window_extension, quad))
    else $error("bad PCI address");
  a_quad_flag: assert property (pci_req |-> pci_quad == quad)
    else $error("bad quad flag");
  a_byte_enables: assert property (pci_req |->
    pci_be_n == be_of(sz, addr[6:5])) else $error("bad byte enables");
  a_lane_pass: assert property (pci_req && write && !quad |->
    pci_wdata[31:0] == (lw_mask[3] | lw_mask[1] ? wdata[63:32] :
    wdata[31:0])) else $error("write lanes moved");
  a_one_cycle: assert property (s_pci_end |=>
    ack && !pci_req ##1 !pci_req ##1 !pci_req) else $error("extra cycle");
  a_rdata_pass: assert property (s_pci_end ##0 !write |=>
    rdata == $past(pci_rdata)) else $error("read data altered");
  a_ack_pulse: assert property (ack |=> !ack) else $error("ack too long");
endmodule
`default_nettype wire

// File: tb/psm_tb_pkg.sv
// Purpose: Expected-value helpers for the sparse translator bench
// Assumes: Full 40-bit processor addresses
// Notes: Kept apart from the design so a shared slip cannot hide
package psm_tb_pkg;
  // Undefined size and offset pairs enable no lane
  localparam logic [63:0] BE_TAB = 64'h0FF0FF18F39C7BDE;
  function automatic logic in_win(logic [39:0] a);
    return a[39:35] == 5'h10 &&
      (a[34:32] < 3'h5 || (a[34:32] == 3'h5 && !a[31]));
  endfunction
  function automatic logic [3:0] be_of(logic [1:0] sz, logic [1:0] off);
    return BE_TAB[{sz, off, 2'b00} +: 4];
  endfunction
  function automatic logic [5:0] hi_of(logic [39:0] a, logic [31:0] x);
    if (a[34:32] < 3'h4) return {x[31:29], a[33:31]};
    if (a[34:32] == 3'h4) return {x[15:11], a[31]};
    return x[7:2];
  endfunction
  function automatic logic [31:0] ad_of(logic [39:0] a, logic [31:0] x,
    logic q);
    return {hi_of(a, x), a[30:8], a[7] & !q, 2'b00};
  endfunction
  function automatic logic [1:0] wsz(logic [3:0] m, logic s);
    return m == 4'hC ? 2'h3 : {s, m[3] | m[2]};
  endfunction
endpackage
